// ==== rcs_pkg.sv ====
// Package of constants and types for the render context switch unit
package rcs_pkg;
    // Context image layout
    localparam int ADDR_W = 32;
    localparam int BASE_LSB = 11;               // Base aligned to 2KB
    localparam int LINE_BYTES = 64;
    localparam int MAX_IMAGE_BYTES = 2048;
    localparam int LINE_W = 6;
    localparam logic [5:0] LINE_SHIFT = 6'h06;  // log2 of line size
    // Reset value of the transfer length, in lines
    localparam logic [5:0] LEN_RESET = 6'h20;
    // Lines of the extended area, written after the main image
    localparam logic [5:0] EXT_LINES = 6'h04;
    // Fields of the current context identifier
    localparam int EXT_SAVE_BIT = 0;
    // Interface register images written in the save
    localparam int NUM_IFREGS = 5;
    localparam logic [31:0] IMM_LOAD_HDR = 32'h11000009;
    typedef enum logic [2:0] {
        RCS_IDLE = 3'b000,
        RCS_SAVE = 3'b001,
        RCS_EXT = 3'b010,
        RCS_RESTORE = 3'b011,
        RCS_UPDATE = 3'b100
    } rcs_state_t;
endpackage

// ==== rcs_context_switch.sv ====
// Render context switch unit: save, restore and identifier update
`timescale 1ns/1ps
`default_nettype none
module rcs_context_switch (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Command from the parser
    input wire logic i_cmd_valid,
    input wire logic i_cmd_from_ring,
    input wire logic [31:0] i_cmd_base,
    input wire logic i_cmd_load_inhibit,
    input wire logic i_cmd_force_reload,
    input wire logic i_cmd_ext_save,
    output logic o_cmd_ready,
    output logic o_cmd_rejected,
    // Debug length register
    input wire logic i_len_write,
    input wire logic [5:0] i_len_data,
    output logic [5:0] o_len,
    // Current identifier
    output logic [31:0] o_ident_base,
    output logic o_ident_ext_save,
    output logic o_ident_valid,
    // Context registers of the hardware context
    input wire logic [31:0] i_parser_mode_reg,
    input wire logic [31:0] i_cache_mode0,
    input wire logic [31:0] i_cache_mode1,
    input wire logic [31:0] i_arbitration_state_reg,
    input wire logic [31:0] i_pipe_stats,
    input wire logic [31:0] i_hw_ctx_data,
    output logic o_ctx_load,
    output logic [31:0] o_ctx_load_data,
    output logic [5:0] o_ctx_load_line,
    // Memory port, one line beat per request
    output logic o_mem_req,
    output logic o_mem_write,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // Status
    output logic o_busy
);
    rcs_pkg::rcs_state_t state;
    rcs_pkg::rcs_state_t next_state;
    logic [31:0] ident_base;
    logic ident_ext;
    logic ident_valid;
    logic [31:0] cmd_base;
    logic cmd_inhibit;
    logic cmd_ext;
    logic [5:0] len;
    logic [5:0] line;
    logic [5:0] next_line;
    logic [31:0] wdata;

    // Byte address of a line within an image; low bits of base dropped
    function automatic logic [31:0] line_addr(input logic [31:0] base, input logic [5:0] idx);
        line_addr = {base[31:rcs_pkg::BASE_LSB], {rcs_pkg::BASE_LSB{1'b0}}}
                    + ({26'h0, idx} << rcs_pkg::LINE_SHIFT);
    endfunction

    // Decode of the incoming command
    wire cmd_take = i_cmd_valid && state == rcs_pkg::RCS_IDLE && i_cmd_from_ring;
    wire mismatch = i_cmd_base[31:rcs_pkg::BASE_LSB] != ident_base[31:rcs_pkg::BASE_LSB];
    wire do_switch = mismatch || !ident_valid;
    wire do_save = ident_valid && (mismatch || i_cmd_force_reload);
    wire run_switch = do_switch || (do_save && i_cmd_force_reload);
    wire beat_done = o_mem_req && i_mem_ack;
    wire last_line = line == len - 6'h01;
    wire last_ext = line == rcs_pkg::EXT_LINES - 6'h01;

    // Handshake: parser held while a switch runs
    assign o_cmd_ready = state == rcs_pkg::RCS_IDLE;
    assign o_cmd_rejected = i_cmd_valid && state == rcs_pkg::RCS_IDLE && !i_cmd_from_ring;
    assign o_busy = state != rcs_pkg::RCS_IDLE;
    assign o_len = len;
    assign o_ident_base = ident_base;
    assign o_ident_ext_save = ident_ext;
    assign o_ident_valid = ident_valid;

    // Save image: line 0 carries the immediate load header and lines 1 to 5
    // the interface registers, so a restore can replay them
    always_comb begin
        case (line)
            6'h00: wdata = rcs_pkg::IMM_LOAD_HDR;
            6'h01: wdata = i_parser_mode_reg;
            6'h02: wdata = i_cache_mode0;
            6'h03: wdata = i_cache_mode1;
            6'h04: wdata = i_arbitration_state_reg;
            6'h05: wdata = i_pipe_stats;
            default: wdata = i_hw_ctx_data;
        endcase
    end

    // Memory request; only image and extended area lines are ever addressed
    assign o_mem_req = state == rcs_pkg::RCS_SAVE || state == rcs_pkg::RCS_EXT
                       || state == rcs_pkg::RCS_RESTORE;
    assign o_mem_write = state != rcs_pkg::RCS_RESTORE && o_mem_req;
    assign o_mem_addr = state == rcs_pkg::RCS_RESTORE ? line_addr(cmd_base, line)
                      : state == rcs_pkg::RCS_EXT ? line_addr(ident_base, 6'(len + line))
                      : line_addr(ident_base, line);
    assign o_mem_wdata = wdata;

    // Next state: save, extended save, restore, then update
    always_comb begin
        next_state = state;
        next_line = line;
        case (state)
            rcs_pkg::RCS_IDLE: begin
                next_line = 6'h00;
                if (cmd_take) begin
                    if (run_switch && do_save) begin
                        next_state = rcs_pkg::RCS_SAVE;
                    end else if (do_switch && !i_cmd_load_inhibit) begin
                        next_state = rcs_pkg::RCS_RESTORE;
                    end else begin
                        next_state = rcs_pkg::RCS_UPDATE;
                    end
                end
            end
            rcs_pkg::RCS_SAVE: begin
                if (beat_done) begin
                    next_line = line + 6'h01;
                    if (last_line) begin
                        next_line = 6'h00;
                        if (ident_ext) begin
                            next_state = rcs_pkg::RCS_EXT;
                        end else if (!cmd_inhibit) begin
                            next_state = rcs_pkg::RCS_RESTORE;
                        end else begin
                            next_state = rcs_pkg::RCS_UPDATE;
                        end
                    end
                end
            end
            rcs_pkg::RCS_EXT: begin
                if (beat_done) begin
                    next_line = line + 6'h01;
                    if (last_ext) begin
                        next_line = 6'h00;
                        next_state = cmd_inhibit ? rcs_pkg::RCS_UPDATE : rcs_pkg::RCS_RESTORE;
                    end
                end
            end
            rcs_pkg::RCS_RESTORE: begin
                if (beat_done) begin
                    next_line = line + 6'h01;
                    if (last_line) begin
                        next_line = 6'h00;
                        next_state = rcs_pkg::RCS_UPDATE;
                    end
                end
            end
            rcs_pkg::RCS_UPDATE: next_state = rcs_pkg::RCS_IDLE;
            default: next_state = rcs_pkg::RCS_IDLE;
        endcase
    end

    // State and line counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= rcs_pkg::RCS_IDLE;
            line <= 6'h00;
        end else begin
            state <= next_state;
            line <= next_line;
        end
    end

    // Latched command fields for the length of the switch
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmd_base <= 32'h00000000;
            cmd_inhibit <= 1'b0;
            cmd_ext <= 1'b0;
        end else if (cmd_take) begin
            cmd_base <= i_cmd_base;
            cmd_inhibit <= i_cmd_load_inhibit;
            cmd_ext <= i_cmd_ext_save;
        end
    end

    // Identifier updated last, after save and restore
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ident_valid <= 1'b0;
            ident_base <= 32'h00000000;
            ident_ext <= 1'b0;
        end else if (state == rcs_pkg::RCS_UPDATE) begin
            ident_valid <= 1'b1;
            ident_base <= {cmd_base[31:rcs_pkg::BASE_LSB], {rcs_pkg::BASE_LSB{1'b0}}};
            ident_ext <= cmd_ext;
        end
    end

    // Length register; writes ignored while a switch runs, zero kept out
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            len <= rcs_pkg::LEN_RESET;
        end else if (i_len_write && state == rcs_pkg::RCS_IDLE && i_len_data != 6'h00) begin
            len <= i_len_data;
        end
    end

    // Restored words load the hardware context
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ctx_load <= 1'b0;
            o_ctx_load_data <= 32'h00000000;
            o_ctx_load_line <= 6'h00;
        end else begin
            o_ctx_load <= state == rcs_pkg::RCS_RESTORE && beat_done;
            o_ctx_load_data <= i_mem_rdata;
            o_ctx_load_line <= line;
        end
    end

    // Assertions
    sequence s_take_save;
        cmd_take && run_switch && do_save;
    endsequence
    sequence s_take_skip;
        cmd_take && !ident_valid;
    endsequence

    AST_FIRST_NO_SAVE: assert property (@(posedge i_clk) disable iff (i_reset)
        s_take_skip |=> state != rcs_pkg::RCS_SAVE)
        else $error("save started with invalid identifier");
    AST_SAVE_START: assert property (@(posedge i_clk) disable iff (i_reset)
        s_take_save |=> state == rcs_pkg::RCS_SAVE && o_mem_write && o_mem_addr == line_addr(ident_base, 6'h00))
        else $error("save not started at stored base");
    AST_INHIBIT: assert property (@(posedge i_clk) disable iff (i_reset)
        state == rcs_pkg::RCS_RESTORE |-> !cmd_inhibit)
        else $error("restore while inhibited");
    AST_UPDATE: assert property (@(posedge i_clk) disable iff (i_reset)
        state == rcs_pkg::RCS_UPDATE |=> ident_valid
            && ident_base[31:rcs_pkg::BASE_LSB] == $past(cmd_base[31:rcs_pkg::BASE_LSB]))
        else $error("identifier not loaded");
    AST_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        o_busy |-> !o_cmd_ready && !o_cmd_rejected)
        else $error("parser not held");
    AST_RING: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_cmd_valid && !i_cmd_from_ring && o_cmd_ready) |=> state == rcs_pkg::RCS_IDLE)
        else $error("batch command accepted");
    AST_EXT: assert property (@(posedge i_clk) disable iff (i_reset)
        state == rcs_pkg::RCS_EXT |-> ident_ext)
        else $error("extended save without flag");
    AST_ALIGN: assert property (@(posedge i_clk) disable iff (i_reset)
        o_mem_req |-> o_mem_addr[5:0] == 6'h00)
        else $error("unaligned line address");
    AST_NOSWITCH: assert property (@(posedge i_clk) disable iff (i_reset)
        (cmd_take && !do_switch && !i_cmd_force_reload) |=> state == rcs_pkg::RCS_UPDATE)
        else $error("switch on matching address");
    AST_LEN_RESET: assert property (@(posedge i_clk)
        i_reset |=> len == rcs_pkg::LEN_RESET)
        else $error("length reset wrong");

    // Steps of a switch that the ordering checks below build on
    sequence s_save_last;
        state == rcs_pkg::RCS_SAVE && beat_done && last_line;
    endsequence
    sequence s_ext_last;
        state == rcs_pkg::RCS_EXT && beat_done && last_ext;
    endsequence
    sequence s_restore_beat;
        state == rcs_pkg::RCS_RESTORE && beat_done;
    endsequence
    sequence s_restore_last;
        s_restore_beat ##0 last_line;
    endsequence

    // The extended area follows the image only when the stored flag asks for it
    AST_NO_EXT: assert property (@(posedge i_clk) disable iff (i_reset)
        s_save_last ##0 !ident_ext |=> state != rcs_pkg::RCS_EXT)
        else $error("extended area written without flag");
    AST_EXT_START: assert property (@(posedge i_clk) disable iff (i_reset)
        s_save_last ##0 ident_ext |=> state == rcs_pkg::RCS_EXT
            && o_mem_addr == {ident_base[31:rcs_pkg::BASE_LSB], {rcs_pkg::BASE_LSB{1'b0}}}
            + ({26'h0, len} << rcs_pkg::LINE_SHIFT))
        else $error("extended area not placed after the image");
    AST_EXT_TO_RESTORE: assert property (@(posedge i_clk) disable iff (i_reset)
        s_ext_last ##0 !cmd_inhibit |=> state == rcs_pkg::RCS_RESTORE && !o_mem_write && line == 6'h00)
        else $error("restore not started after extended save");

    // Restore reads from the command base and hands each word on one cycle later
    AST_RESTORE_BASE: assert property (@(posedge i_clk) disable iff (i_reset)
        (state == rcs_pkg::RCS_RESTORE && line == 6'h00)
            |-> o_mem_addr == {cmd_base[31:rcs_pkg::BASE_LSB], {rcs_pkg::BASE_LSB{1'b0}}})
        else $error("restore not read from command base");
    AST_LOAD: assert property (@(posedge i_clk) disable iff (i_reset)
        s_restore_beat |=> o_ctx_load && o_ctx_load_data == $past(i_mem_rdata)
            && o_ctx_load_line == $past(line))
        else $error("restored word not handed to the context");
    AST_NO_LOAD: assert property (@(posedge i_clk) disable iff (i_reset)
        !(state == rcs_pkg::RCS_RESTORE && beat_done) |=> !o_ctx_load)
        else $error("context loaded without a restore beat");
    AST_RESTORE_DONE: assert property (@(posedge i_clk) disable iff (i_reset)
        s_restore_last |=> state == rcs_pkg::RCS_UPDATE)
        else $error("identifier update not after restore");

    // Image layout: header first, then the parser mode register; also line bound and write window
    AST_HEADER: assert property (@(posedge i_clk) disable iff (i_reset)
        (state == rcs_pkg::RCS_SAVE && line == 6'h00) |-> o_mem_wdata == rcs_pkg::IMM_LOAD_HDR)
        else $error("image does not open with load header");
    AST_MODE_SAVED: assert property (@(posedge i_clk) disable iff (i_reset)
        (state == rcs_pkg::RCS_SAVE && line == 6'h01) |-> o_mem_wdata == i_parser_mode_reg)
        else $error("parser mode not saved");
    AST_LINE_BOUND: assert property (@(posedge i_clk) disable iff (i_reset)
        (state == rcs_pkg::RCS_SAVE || state == rcs_pkg::RCS_RESTORE) |-> line < len)
        else $error("line beyond transfer length");
    AST_WRITE_ONLY_SAVE: assert property (@(posedge i_clk) disable iff (i_reset)
        o_mem_write |-> state == rcs_pkg::RCS_SAVE || state == rcs_pkg::RCS_EXT)
        else $error("memory written outside a save");

    // Command fields and identifier must not drift while a switch runs;
    // a change here would mix two contexts in one image
    AST_CMD_HELD: assert property (@(posedge i_clk) disable iff (i_reset)
        o_busy |=> $stable(cmd_base) && $stable(cmd_inhibit) && $stable(cmd_ext))
        else $error("command fields changed during switch");
    AST_IDENT_HELD: assert property (@(posedge i_clk) disable iff (i_reset)
        state != rcs_pkg::RCS_UPDATE |=> $stable(ident_base) && $stable(ident_valid))
        else $error("identifier changed outside update");
    AST_UPDATE_LAST: assert property (@(posedge i_clk) disable iff (i_reset)
        state == rcs_pkg::RCS_UPDATE |=> state == rcs_pkg::RCS_IDLE && o_cmd_ready)
        else $error("parser not released after update");
endmodule
`default_nettype wire

// ==== rcs_mem_model.sv ====
// Main memory model holding context images, answering beats with varying delay
`timescale 1ns/1ps
`default_nettype none
module rcs_mem_model (
    // Clock
    input wire logic i_clk,
    // Beat request from the unit
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    // Answer
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [logic [31:0]];
    int unsigned wait_cnt = 0;
    initial begin
        o_ack = 1'b0;
        o_rdata = 32'h0;
    end
    // Ack after zero to two idle cycles; read data is inverted between answers so a stale sample shows
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && o_ack && i_write) mem[i_addr] = i_wdata;
        if (i_req && !o_ack) begin
            if (wait_cnt == 0) begin
                o_ack <= 1'b1;
                o_rdata <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
                wait_cnt = $urandom_range(2);
            end else begin
                wait_cnt--;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rcs_context_switch_bench.sv ====
// Self-checking bench for the context switch unit
`timescale 1ns/1ps
`default_nettype none
module rcs_context_switch_bench;
    typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic c;} rcs_beat_t;
    logic i_clk = 0, i_reset = 1, cv = 0, ring = 1, inh = 0, frc = 0, ext = 0, lw = 0;
    logic [31:0] cb = 0, hw = 0, rd;
    logic [31:0] regs [5] = '{default: 32'h0};
    logic [5:0] ld = 0, o_len;
    logic ready, rej, busy, ivalid, iext, req, wr, ack;
    logic [31:0] ibase, addr, wd;
    logic [31:0] cur_b = 0;
    logic cur_v = 0, cur_e = 0;
    int errors = 0, n_compared = 0;
    int len = 8;
    rcs_beat_t q[$];
    rcs_beat_t e;
    logic cl;
    logic [5:0] cl_l;
    logic [31:0] cl_d;
    logic [31:0] img [logic [31:0]];
    logic [37:0] lq[$];
    logic [37:0] le;

    rcs_context_switch DUT (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(cv), .i_cmd_from_ring(ring),
        .i_cmd_base(cb), .i_cmd_load_inhibit(inh), .i_cmd_force_reload(frc), .i_cmd_ext_save(ext),
        .o_cmd_ready(ready), .o_cmd_rejected(rej), .i_len_write(lw), .i_len_data(ld), .o_len(o_len),
        .o_ident_base(ibase), .o_ident_ext_save(iext), .o_ident_valid(ivalid),
        .i_parser_mode_reg(regs[0]), .i_cache_mode0(regs[1]), .i_cache_mode1(regs[2]),
        .i_arbitration_state_reg(regs[3]), .i_pipe_stats(regs[4]), .i_hw_ctx_data(hw),
        .o_ctx_load(cl), .o_ctx_load_data(cl_d), .o_ctx_load_line(cl_l), .o_mem_req(req), .o_mem_write(wr),
        .o_mem_addr(addr), .o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_rdata(rd), .o_busy(busy));
    rcs_mem_model mem (.i_clk(i_clk), .i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wd),
        .o_ack(ack), .o_rdata(rd));

    // Clock of 100 ns period
    initial begin
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input logic [32:0] g, input logic [32:0] x);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Each beat taken by memory is matched against the oldest expected beat
    always @(posedge i_clk) begin
        if (req === 1'b1 && ack === 1'b1) begin
            if (q.size() == 0) begin
                chk(33'h1, 33'h0);
            end else begin
                e = q.pop_front();
                chk({wr, addr}, {e.w, e.a});
                if (e.c) chk({1'b0, wd}, {1'b0, e.d});
            end
        end
    end

    // Each restored word handed to the context is matched against the saved image
    always @(posedge i_clk) begin
        if (cl === 1'b1) begin
            if (lq.size() == 0) begin
                chk(33'h1, 33'h0);
            end else begin
                le = lq.pop_front();
                chk({1'b0, cl_d}, {1'b0, le[31:0]});
                chk({27'h0, cl_l}, {27'h0, le[37:32]});
            end
        end
    end

    // Notes expected beats, issues one command, waits for idle and checks the identifier
    task automatic do_cmd(input logic [31:0] b, input logic ih, input logic fr, input logic ex, input logic rg);
        logic [31:0] nb;
        logic sw, sv;
        logic [31:0] wv;
        int t;
        nb = {b[31:11], 11'h000};
        sw = rg && (!cur_v || nb != cur_b);
        sv = rg && cur_v && (nb != cur_b || fr);
        foreach (regs[k]) regs[k] = $urandom();
        hw = $urandom();
        if (sv) for (int i = 0; i < len; i++) begin
            wv = i == 0 ? rcs_pkg::IMM_LOAD_HDR : i < 6 ? regs[i-1] : hw;
            q.push_back('{1'b1, cur_b + 32'(64 * i), wv, 1'b1});
            img[cur_b + 32'(64 * i)] = wv;
        end
        if (sv && cur_e) for (int i = 0; i < 4; i++) q.push_back('{1'b1, cur_b + 32'(64 * (len + i)), 32'h0, 1'b0});
        if (rg && (sw || fr) && !ih) for (int i = 0; i < len; i++) begin
            q.push_back('{1'b0, nb + 32'(64 * i), 32'h0, 1'b0});
            lq.push_back({6'(i), img[nb + 32'(64 * i)]});
        end
        cv = 1;
        cb = b;
        inh = ih;
        frc = fr;
        ext = ex;
        ring = rg;
        #1 chk({32'h0, rej}, {32'h0, !rg});
        @(negedge i_clk);
        cv = 0;
        t = 0;
        // Parser held and length writes refused while the switch runs
        while (busy !== 1'b0 && t < 500) begin
            chk({32'h0, ready}, 33'h0);
            lw = 1;
            ld = 6'($urandom_range(63, 1));
            @(negedge i_clk);
            t++;
        end
        lw = 0;
        chk({32'h0, busy}, 33'h0);
        chk({27'h0, o_len}, {27'h0, 6'(len)});
        if (rg) begin
            cur_b = nb;
            cur_v = 1;
            cur_e = ex;
        end
        chk(33'(q.size()), 33'h0);
        chk(33'(lq.size()), 33'h0);
        chk({ivalid, ibase}, {cur_v, cur_b});
        chk({32'h0, iext}, {32'h0, cur_e});
    endtask

    // Main sequence
    initial begin
        logic [31:0] a, b;
        void'($urandom(55048));
        a = $urandom();
        b = a ^ 32'h00400000 ^ 32'h7FF;
        repeat (5) @(negedge i_clk);
        i_reset = 0;
        chk({27'h0, o_len}, 33'h20);
        chk({32'h0, ivalid}, 33'h0);
        lw = 1;
        ld = 6'h08;
        @(negedge i_clk);
        ld = 6'h00;
        @(negedge i_clk);
        lw = 0;
        chk({27'h0, o_len}, 33'h08);
        do_cmd(a, 1, 0, 0, 1);
        do_cmd(b, 1, 0, 1, 1);
        do_cmd(a, 0, 0, 0, 1);
        do_cmd(a, 0, 0, 1, 1);
        do_cmd(a, 0, 1, 0, 1);
        do_cmd(b, 0, 0, 0, 0);
        do_cmd(b, 1, 0, 0, 1);
        conclude();
    end

    // Watchdog well beyond the expected run of about two hundred cycles
    initial begin
        #2000000;
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
